// File: bench/ssrdq_ctl_model.sv
// Memory controller model driving the SRAM command and data pins
`default_nettype none
module ssrdq_ctl_model (
  // Clock
  input wire logic clk,
  // Command pins
  output logic chip_select_one_n,
  output logic chip_select_two,
  output logic chip_select_three_n,
  output logic adv_ld_n,
  output logic write_enable_n,
  output logic [17:0] addr,
  output logic [3:0] byte_write_select_n,
  // Parity and data driven by the controller
  output logic [35:0] bus_data
);
  logic wr_last;
  logic [35:0] d_last;

  initial begin
    {chip_select_one_n, chip_select_two, chip_select_three_n} = 3'h5;
    {adv_ld_n, write_enable_n, wr_last} = 3'h1;
    addr = '0;
    byte_write_select_n = '0;
    bus_data = '0;
    d_last = '0;
  end

  // Called at a rising edge; write data follows one cycle after its command
  task automatic op(input logic wr, input logic sel, input logic [17:0] a,
                    input logic [3:0] m, input logic [35:0] d);
    adv_ld_n <= 1'b0;
    write_enable_n <= ~wr;
    chip_select_one_n <= ~sel;
    chip_select_two <= sel;
    chip_select_three_n <= ~sel;
    addr <= a;
    byte_write_select_n <= m;
    // Released bus toggles so stale data never passes as a match
    bus_data <= wr_last ? d_last : ~bus_data;
    wr_last <= wr & sel;
    d_last <= d;
  endtask : op
endmodule : ssrdq_ctl_model
`default_nettype wire

// File: bench/ssrdq_port_bench.sv
// Self-checking bench of the SRAM data port
`default_nettype none
module ssrdq_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wr;
    logic sel;
    logic [17:0] a;
    logic [3:0] m;
    logic [35:0] d;
    logic eoe;
    logic cq;
    logic [35:0] q;
  } ssrdq_row_s;
  // Each row checks the command taken at its own drive edge, i.e. the row before
  ssrdq_row_s rows [10] = '{
    '{1'h1, 1'h1, 18'h5, 4'h0, 36'hA12345678, 1'h0, 1'h0, 36'h0},
    '{1'h1, 1'h1, 18'h5, 4'h5, 36'h5FFFFFFFF, 1'h0, 1'h0, 36'h0},
    '{1'h0, 1'h1, 18'h5, 4'h0, 36'h0, 1'h0, 1'h0, 36'h0},
    '{1'h1, 1'h1, 18'h9, 4'h0, 36'h30BADF00D, 1'h1, 1'h1, 36'h0FF34FF78},
    '{1'h0, 1'h1, 18'h9, 4'h0, 36'h0, 1'h0, 1'h0, 36'h0},
    '{1'h0, 1'h0, 18'h0, 4'h0, 36'h0, 1'h1, 1'h1, 36'h30BADF00D},
    '{1'h0, 1'h1, 18'h5, 4'h0, 36'h0, 1'h0, 1'h0, 36'h0},
    '{1'h0, 1'h1, 18'h9, 4'h0, 36'h0, 1'h0, 1'h1, 36'h0FF34FF78},
    '{1'h0, 1'h0, 18'h0, 4'h0, 36'h0, 1'h1, 1'h1, 36'h30BADF00D},
    '{1'h0, 1'h0, 18'h0, 4'h0, 36'h0, 1'h0, 1'h0, 36'h0}};
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic clock_qualify_n, chip_select_one_n, chip_select_two, chip_select_three_n;
  logic adv_ld_n, write_enable_n, output_enable_n, burst_mode, dq_oe, parity_lines_oe;
  logic tck, tdi, tdo, capture_ready;
  logic [17:0] addr;
  logic [3:0] byte_write_select_n, parity_lines_in, parity_lines_out;
  logic [31:0] dq_in, dq_out;
  logic [35:0] bus_data;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  // Wire level from both drivers
  assign dq_in = dq_oe ? dq_out : bus_data[31:0];
  assign parity_lines_in = parity_lines_oe ? parity_lines_out : bus_data[35:32];

  ssrdq_port i_dut (
    .clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .clock_qualify_n, .chip_select_one_n, .chip_select_two, .chip_select_three_n,
    .adv_ld_n, .write_enable_n, .addr, .byte_write_select_n, .output_enable_n, .burst_mode,
    .dq_in, .dq_out, .dq_oe, .parity_lines_in, .parity_lines_out, .parity_lines_oe,
    .tck, .tdi, .tdo, .capture_ready);
  ssrdq_ctl_model i_ctl (
    .clk, .chip_select_one_n, .chip_select_two, .chip_select_three_n,
    .adv_ld_n, .write_enable_n, .addr, .byte_write_select_n, .bus_data);

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb

  task automatic final_report;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    {nrst, psel, penable, pwrite, tck, tdi, clock_qualify_n, output_enable_n} = '0;
    {burst_mode, paddr, pwdata} = '0;
    repeat (8) @(posedge clk);
    chk(36'({dq_oe, tdo, pready, capture_ready}), 36'h3);
    nrst <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      i_ctl.op(rows[i].wr, rows[i].sel, rows[i].a, rows[i].m, rows[i].d);
      @(negedge clk);
      chk(36'({parity_lines_oe, dq_oe}), 36'({2{rows[i].eoe}}));
      if (rows[i].cq) chk({parity_lines_out, dq_out}, rows[i].q);
    end
    // Suspended clock must not take the read
    @(posedge clk);
    clock_qualify_n <= 1'b1;
    i_ctl.op(1'b0, 1'b1, 18'h5, 4'h0, 36'h0);
    repeat (3) @(posedge clk);
    @(negedge clk) chk({parity_lines_out, dq_out}, 36'h30BADF00D);
    @(posedge clk) clock_qualify_n <= 1'b0;
    @(posedge clk);
    @(negedge clk) chk({dq_oe, parity_lines_out, dq_out}, 37'h00FF34FF78);
    @(posedge clk) output_enable_n <= 1'b1;
    @(negedge clk) chk(36'(dq_oe), 36'h0);
    @(posedge clk) output_enable_n <= 1'b0;
    @(negedge clk) chk(36'(dq_oe), 36'h1);
    @(posedge clk) i_ctl.op(1'b0, 1'b0, 18'h0, 4'h0, 36'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'h008, 32'h0);
      chk(36'(q), (i == 2) ? 36'h9 : 36'h5);
    end
    apb(1'b0, 12'h004, 32'h0);
    chk(36'({q[3], q[0]}), 36'h2);
    apb(1'b0, 12'h00C, 32'h0);
    chk(36'(e), 36'h1);
    // Overfill the log by one entry
    for (int i = 0; i < 17; i++) begin
      @(posedge clk) i_ctl.op(1'b1, 1'b1, 18'(i), 4'h0, 36'h0);
    end
    @(posedge clk) i_ctl.op(1'b0, 1'b0, 18'h0, 4'h0, 36'h0);
    repeat (3) @(posedge clk);
    chk(36'(capture_ready), 36'h0);
    for (int i = 0; i < 17; i++) begin
      apb(1'b0, 12'h008, 32'h0);
      chk(36'(q), (i == 16) ? 36'h0 : 36'(i));
    end
    chk(36'(capture_ready), 36'h1);
    // Scan bypass: new bit appears only after the test clock falls
    tdi <= 1'b1;
    repeat (8) @(posedge clk);
    tck <= 1'b1;
    repeat (8) @(posedge clk);
    chk(36'(tdo), 36'h0);
    tck <= 1'b0;
    repeat (8) @(posedge clk);
    chk(36'(tdo), 36'h1);
    final_report();
  end
endmodule : ssrdq_port_bench
`default_nettype wire

// File: src/ssrdq_fifo.sv
// Write log FIFO with valid and ready on both sides
`default_nettype none
module ssrdq_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
    $error("ssrdq_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [CW-1:0] cnt;
  } ssrdq_fifo_s;

  ssrdq_fifo_s r, n;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = r.cnt != CW'(DEPTH);
  assign out_valid = r.cnt != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[r.rd];
  assign count = r.cnt;

  always_comb begin
    n = r;
    if (push) begin
      n.wr = AW'(r.wr + 1'b1);
    end
    if (pop) begin
      n.rd = AW'(r.rd + 1'b1);
    end
    if (push && !pop) begin
      n.cnt = CW'(r.cnt + 1'b1);
    end else if (pop && !push) begin
      n.cnt = CW'(r.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[r.wr] <= in_data;
    end
  end

endmodule : ssrdq_fifo
`default_nettype wire

// File: src/ssrdq_pkg.sv
// Shared types of the SRAM data port
`default_nettype none
package ssrdq_pkg;

  // Operation owning the current data cycle
  typedef enum logic [1:0] {
    OP_DESEL = 2'h0,
    OP_READ = 2'h1,
    OP_WRITE = 2'h2
  } ssrdq_op_e;

endpackage : ssrdq_pkg
`default_nettype wire

// File: src/ssrdq_port.sv
// Data side of a flow-through burst SRAM with APB status and write log
//
// Our own choices: the APB register port and the address map.
`include "ssrdq_regs.svh"
`default_nettype none
module ssrdq_port #(
  parameter int ADDR_W = 18,
  parameter int BYTES = 4,
  parameter int LOG_DEPTH = `SSRDQ_LOG_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller command pins
  input wire logic clock_qualify_n,
  input wire logic chip_select_one_n,
  input wire logic chip_select_two,
  input wire logic chip_select_three_n,
  input wire logic adv_ld_n,
  input wire logic write_enable_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [BYTES-1:0] byte_write_select_n,
  input wire logic output_enable_n,
  input wire logic burst_mode,
  // Data and parity pins
  input wire logic [8*BYTES-1:0] dq_in,
  output logic [8*BYTES-1:0] dq_out,
  output logic dq_oe,
  input wire logic [BYTES-1:0] parity_lines_in,
  output logic [BYTES-1:0] parity_lines_out,
  output logic parity_lines_oe,
  // Boundary scan
  input wire logic tck,
  input wire logic tdi,
  output logic tdo,
  // Write log back-pressure
  output logic capture_ready
);
  localparam int DW = 8 * BYTES;
  localparam int LW = 9 * BYTES;
  localparam int CW = $clog2(LOG_DEPTH + 1);

  if (BYTES < 1 || BYTES > 4 || ADDR_W < 2 || ADDR_W > 24 || LOG_DEPTH > 256) begin : g_bad
    $error("ssrdq_port: BYTES, ADDR_W or LOG_DEPTH out of range");
  end

  typedef logic [LW-1:0] ssrdq_word_t;

  typedef struct packed {
    logic mode;
    logic mode_done;
    ssrdq_pkg::ssrdq_op_e op;
    logic [ADDR_W-1:0] base;
    logic [1:0] cnt;
    logic drive;
    logic [DW-1:0] dout;
    logic [BYTES-1:0] pout;
    logic [ADDR_W-1:0] waddr;
    logic [BYTES-1:0] wmask;
    logic log_en;
    logic [31:0] prdata;
    logic pslverr;
    logic [2:0] tck_s;
    logic [1:0] tdi_s;
    logic shift;
    logic tdo;
  } ssrdq_st_s;

  // Lane i is {parity bit i, data byte i}
  function automatic ssrdq_word_t pack_lanes(input logic [DW-1:0] d,
                                             input logic [BYTES-1:0] p);
    ssrdq_word_t w;
    for (int i = 0; i < BYTES; i++) begin
      w[9*i +: 9] = {p[i], d[8*i +: 8]};
    end
    return w;
  endfunction : pack_lanes

  function automatic ssrdq_word_t merge_lanes(input ssrdq_word_t old,
                                              input ssrdq_word_t nw,
                                              input logic [BYTES-1:0] m);
    ssrdq_word_t w;
    for (int i = 0; i < BYTES; i++) begin
      w[9*i +: 9] = m[i] ? nw[9*i +: 9] : old[9*i +: 9];
    end
    return w;
  endfunction : merge_lanes

  function automatic logic [1:0] burst_low(input logic [1:0] b, input logic [1:0] c,
                                           input logic il);
    return il ? (b ^ c) : 2'(b + c);
  endfunction : burst_low

  ssrdq_st_s r, n;
  ssrdq_word_t mem [2**ADDR_W];
  ssrdq_word_t wr_word, rd_word;
  logic [ADDR_W-1:0] naddr;
  logic ce, sel, wr_commit, setup, access, pop;
  logic tck_rise, tck_fall;
  logic log_valid;
  logic [31:0] log_data, stat;
  logic [CW-1:0] log_count;

  // Suspended clock: command, burst, write and read data state hold
  assign ce = ~clock_qualify_n;
  assign sel = ~chip_select_one_n & chip_select_two & ~chip_select_three_n;
  // Write data sits on the pins one cycle after its command
  assign wr_commit = ce && r.op == ssrdq_pkg::OP_WRITE;
  // Mask per lane covers data byte and parity bit
  assign wr_word = merge_lanes(mem[r.waddr], pack_lanes(dq_in, parity_lines_in),
                               r.wmask);
  assign tck_rise = r.tck_s[1] & ~r.tck_s[2];
  assign tck_fall = ~r.tck_s[1] & r.tck_s[2];
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pop = access && !pwrite && paddr == `SSRDQ_LOG_OFS;

  always_comb begin
    stat = 32'h0000_0000;
    stat[`SSRDQ_STAT_MODE] = r.mode;
    stat[`SSRDQ_STAT_DRIVE] = r.drive;
    stat[`SSRDQ_STAT_DESEL] = r.op == ssrdq_pkg::OP_DESEL;
    stat[`SSRDQ_STAT_EMPTY] = ~log_valid;
    stat[`SSRDQ_STAT_FULL] = ~capture_ready;
    stat[`SSRDQ_STAT_CNT +: CW] = log_count;
  end

  always_comb begin
    n = r;
    // Strap is static; taken once after reset release
    if (!r.mode_done) begin
      n.mode = burst_mode;
      n.mode_done = 1'b1;
    end
    if (ce) begin
      if (!adv_ld_n) begin
        n.base = addr;
        n.cnt = 2'h0;
        if (!sel) begin
          n.op = ssrdq_pkg::OP_DESEL;
        end else if (write_enable_n) begin
          n.op = ssrdq_pkg::OP_READ;
        end else begin
          n.op = ssrdq_pkg::OP_WRITE;
        end
      end else if (r.op != ssrdq_pkg::OP_DESEL) begin
        // Burst continues with the type latched at load
        n.cnt = 2'(r.cnt + 2'h1);
      end
    end
    naddr = {n.base[ADDR_W-1:2], burst_low(n.base[1:0], n.cnt, r.mode)};
    rd_word = mem[naddr];
    // Write landing this edge must be seen by a read of the same word
    if (wr_commit && naddr == r.waddr) begin
      rd_word = wr_word;
    end
    if (ce) begin
      n.waddr = naddr;
      n.wmask = ~byte_write_select_n;
      // Float in write data, on leaving deselect, and while deselected
      n.drive = n.op == ssrdq_pkg::OP_READ && r.op != ssrdq_pkg::OP_DESEL;
      if (n.op == ssrdq_pkg::OP_READ) begin
        for (int i = 0; i < BYTES; i++) begin
          n.dout[8*i +: 8] = rd_word[9*i +: 8];
          n.pout[i] = rd_word[9*i + 8];
        end
      end
    end
    // Scan port on the synchronised test clock
    n.tck_s = {r.tck_s[1:0], tck};
    n.tdi_s = {r.tdi_s[0], tdi};
    if (tck_rise) begin
      n.shift = r.tdi_s[1];
    end
    if (tck_fall) begin
      n.tdo = r.shift;
    end
    // Read data latched in setup so it is stable through access
    if (setup) begin
      n.pslverr = 1'b0;
      case (paddr)
        `SSRDQ_CTRL_OFS: begin
          n.prdata = 32'h0000_0000;
          n.prdata[`SSRDQ_CTRL_LOG_EN] = r.log_en;
        end
        `SSRDQ_STAT_OFS: n.prdata = stat;
        `SSRDQ_LOG_OFS: n.prdata = log_valid ? log_data : 32'h0000_0000;
        default: begin
          n.prdata = 32'h0000_0000;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (access && pwrite && paddr == `SSRDQ_CTRL_OFS) begin
      n.log_en = pwdata[`SSRDQ_CTRL_LOG_EN];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.log_en <= `SSRDQ_LOG_EN_RST;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_commit) begin
      mem[r.waddr] <= wr_word;
    end
  end

  // Log of written addresses; full log drops entries, shown on capture_ready
  ssrdq_fifo #(
    .W(32),
    .DEPTH(LOG_DEPTH)
  ) u_log (
    .clk(clk),
    .nrst(nrst),
    .in_valid(wr_commit && r.log_en),
    .in_ready(capture_ready),
    .in_data(32'(r.waddr)),
    .out_valid(log_valid),
    .out_ready(pop),
    .out_data(log_data),
    .count(log_count)
  );

  // Output enable is combinational so it acts without a clock
  assign dq_oe = r.drive & ~output_enable_n;
  assign parity_lines_oe = r.drive & ~output_enable_n;
  assign dq_out = r.dout;
  assign parity_lines_out = r.pout;
  assign tdo = r.tdo;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign pready = 1'b1;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_write_capture: assert property (
    wr_commit && (&r.wmask) |=>
      mem[$past(r.waddr)] == $past(pack_lanes(dq_in, parity_lines_in)))
    else $error("full write did not store the pin word");

  a_read_flow: assert property (
    ce && n.op == ssrdq_pkg::OP_READ |=>
      dq_out[7:0] == $past(rd_word[7:0]) && parity_lines_out[0] == $past(rd_word[8]))
    else $error("read data is not the word of the previous edge");

  a_oe_high_float: assert property (
    output_enable_n |-> !dq_oe && !parity_lines_oe)
    else $error("pins driven with output enable high");

  a_write_float: assert property (
    r.op == ssrdq_pkg::OP_WRITE || r.op == ssrdq_pkg::OP_DESEL |-> !dq_oe)
    else $error("pins driven in write data or deselect cycle");

  a_emerge_float: assert property (
    ce && r.op == ssrdq_pkg::OP_DESEL ##1 1'b1 |-> !dq_oe && !parity_lines_oe)
    else $error("pins driven in first cycle after deselect");

  a_parity_mask: assert property (
    wr_commit && !r.wmask[0] |=> mem[$past(r.waddr)][8:0] == $past(mem[r.waddr][8:0]))
    else $error("masked lane was written");

  a_burst_step: assert property (
    ce && adv_ld_n && r.op != ssrdq_pkg::OP_DESEL |=>
      r.cnt == 2'($past(r.cnt) + 2'h1) && $stable(r.base))
    else $error("burst counter did not advance");

  a_tdo_fall: assert property (
    $changed(tdo) |-> $past(tck_fall))
    else $error("scan output changed away from test clock fall");

  a_hold_suspend: assert property (
    clock_qualify_n |=> $stable(dq_out) && $stable(parity_lines_out) && $stable(r.op))
    else $error("state moved while clock was suspended");

  a_oe_async: assert property (
    r.drive && !output_enable_n |-> dq_oe && parity_lines_oe)
    else $error("read cycle not driven with output enable low");

endmodule : ssrdq_port
`default_nettype wire

// File: src/ssrdq_regs.svh
// Register offsets, field positions and reset values of the SRAM data port
// How it works
// - Data pins taken as inputs are captured into the data register on clock rise.
// - A read drives the word addressed at the previous clock rise, no extra stage.
// - Output enable low lets data and parity drive; high floats them.
// - Outputs float in write data cycles, first cycle after deselect, and deselected.
// - Parity pins act as data pins; each parity bit writes only with its byte select.
// - Burst order strap low gives linear bursts, high or open gives interleaved; the code latches burst_mode as is, with no default for an open strap.
// - Scan output changes on test clock fall, for sampling on the next rise.
// - Clock edges count only while clock qualify is low; otherwise SRAM state holds, scan and APB logic run on.
// - Output enable acts asynchronously, active low, gated by internal drive logic.
`ifndef SSRDQ_REGS_SVH
`define SSRDQ_REGS_SVH

`define SSRDQ_CTRL_OFS 12'h000
`define SSRDQ_STAT_OFS 12'h004
`define SSRDQ_LOG_OFS 12'h008

`define SSRDQ_CTRL_LOG_EN 0
`define SSRDQ_LOG_EN_RST 1'h1

`define SSRDQ_STAT_MODE 0
`define SSRDQ_STAT_DRIVE 1
`define SSRDQ_STAT_DESEL 2
`define SSRDQ_STAT_EMPTY 3
`define SSRDQ_STAT_FULL 4
`define SSRDQ_STAT_CNT 8

`define SSRDQ_LOG_DEPTH 16

`endif
